// ===== bbseq_far_end.sv
`timescale 1ns/1ps
module bbseq_far_end (
   input  wire logic        mclk,
   input  wire logic        failLow,
   input  wire logic [31:0] noise,
   input  wire logic        addrReq,
   input  wire logic        strReq,
   output logic [31:0]      pins = 32'hffffffff,
   output logic             hostAddressSet = 1'b0,
   output logic             hostStringRequest = 1'b0
);
   // Unselected pins carry noise so a wrong select decode shows up.
   always @(posedge mclk) begin
      pins <= {noise[31:11], !failLow, noise[9:0]};
      hostAddressSet <= addrReq;
      hostStringRequest <= strReq;
   end
endmodule

// ===== bbseq_params.svh
`ifndef BBSEQ_PARAMS_SVH
`define BBSEQ_PARAMS_SVH

// Register indices; each register is one word, so the bus byte address is
// four times its index.
`define BBSEQ_IDX_ADDR_LO    16'h413c
`define BBSEQ_IDX_ADDR_HI    16'h413d
`define BBSEQ_IDX_STR_LO     16'h413e
`define BBSEQ_IDX_STR_HI     16'h413f
`define BBSEQ_IDX_CTRL       16'h4140
`define BBSEQ_IDX_STATUS     16'h4141

`define BBSEQ_RST_LO         8'hd0
`define BBSEQ_RST_HI         8'h07
`define BBSEQ_RST_CTRL       8'h14

`define BBSEQ_CTRL_EN_BIT    0
`define BBSEQ_CTRL_SEL_LSB   1
`define BBSEQ_CTRL_SEL_MSB   5

`define BBSEQ_TICK_MS        10
`define BBSEQ_CLK_KHZ        100000
`define BBSEQ_TICK_CYCLES    (`BBSEQ_TICK_MS * `BBSEQ_CLK_KHZ)
`define BBSEQ_DETACH_CYCLES  16

`define BBSEQ_BCD_VERSION    16'h0110
`define BBSEQ_CFG_UNSPEC     2'b00

`endif

// ===== bbseq_pkg.sv
package bbseq_pkg;
   typedef enum logic [2:0] {
      SNormal,
      SDetachIn,
      SBillboard,
      SDetachOut,
      SHold
   } bbseq_state_e;
endpackage

// ===== bbseq_sva.sv
`timescale 1ns/1ps
module bbseq_sva #(
   parameter int DetachCycles = 16
) (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        deviceConnect,
   input wire logic        billboardIdentity,
   input wire logic        hostStringRequest,
   input wire logic        stringReturn,
   input wire logic [15:0] bcdVersion,
   input wire logic [1:0]  configuredState
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic [7:0] lowCnt_q;
   // Only a detach that starts after reset is counted, not the power-up low.
   always_ff @(posedge mclk)
      if (rst) lowCnt_q <= 8'h00;
      else if ($fell(deviceConnect) || (lowCnt_q != 0 && !deviceConnect))
         lowCnt_q <= lowCnt_q + 8'h01;
      else lowCnt_q <= 8'h00;
   answer_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   string_ret_a: assert property (
      $rose(hostStringRequest) && billboardIdentity |=> stringReturn)
      else $error("string not returned");
   version_fix_a: assert property (!$past(rst) |-> bcdVersion == 16'h0110)
      else $error("bad version");
   config_unspec_a: assert property (configuredState == 2'b00)
      else $error("bad configured state");
   attach_pair_a: assert property (
      $rose(billboardIdentity) |-> $rose(deviceConnect))
      else $error("identity without reattach");
   leave_detach_a: assert property (
      $fell(billboardIdentity) |-> !deviceConnect || $rose(deviceConnect))
      else $error("identity left while attached");
   detach_len_a: assert property (
      $rose(deviceConnect) && lowCnt_q != 0 |-> lowCnt_q == DetachCycles)
      else $error("detach length wrong");
   cover property ($rose(billboardIdentity));
   cover property (stringReturn);
   cover property (pslverr);
endmodule

bind billboard_attach_sequencer bbseq_sva #(.DetachCycles(DetachCycles)) u_sva (
   .mclk, .rst, .psel, .penable, .pready, .pslverr, .deviceConnect,
   .billboardIdentity, .hostStringRequest, .stringReturn, .bcdVersion,
   .configuredState);

// ===== bbseq_tick_div.sv
`timescale 1ns/1ps
`include "bbseq_params.svh"

module bbseq_tick_div #(
   parameter int TickCycles = `BBSEQ_TICK_CYCLES
) (
   input  wire logic mclk,
   input  wire logic rst,
   output logic      tick
);
   logic [31:0] cnt_q;

   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_q <= 32'h0;
         tick  <= 1'b0;
      end else if (cnt_q == 32'(TickCycles - 1)) begin
         cnt_q <= 32'h0;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'h1;
         tick  <= 1'b0;
      end
   end
endmodule

// ===== billboard_attach_sequencer.sv
// Behaviour
// - Failure pin low starts billboard sequence.
// - Detach internal device, reattach as billboard.
// - Billboard descriptors follow class revision 1.1.
// - Address set starts the address dwell timer.
// - Address timer expiry ignores host traffic.
// - Address timer defaults to 20 seconds.
// - Billboard only on failure, configured unspecified.
// - Capability set static, failure case only.
// - String request returns string, starts timer.
// - String timer defaults to 20 seconds.
// - First timer expiry detaches billboard device.
// - Then reattach with standard descriptors.
// - Address timeout 16 bits, 10 ms, 07d0.
// - String timeout 16 bits, 10 ms steps.
// - Sequence inactive unless enable bit set.
// - Five-bit select picks pin, default 01010.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "bbseq_params.svh"

module billboard_attach_sequencer
   import bbseq_pkg::*;
#(
   parameter int PinCount     = 32,
   parameter int TickCycles   = `BBSEQ_TICK_CYCLES,
   parameter int DetachCycles = `BBSEQ_DETACH_CYCLES
) (
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [17:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic                     pready,
   output logic [31:0]              prdata,
   output logic                     pslverr,
   input  wire logic [PinCount-1:0] generalPurposePin,
   input  wire logic                hostAddressSet,
   input  wire logic                hostStringRequest,
   output logic                     deviceConnect,
   output logic                     billboardIdentity,
   output logic                     stringReturn,
   output logic [15:0]              bcdVersion,
   output logic [1:0]               configuredState
);
   bbseq_state_e state_q;
   logic [7:0]  addrLo_q;
   logic [7:0]  addrHi_q;
   logic [7:0]  strLo_q;
   logic [7:0]  strHi_q;
   logic [7:0]  ctrl_q;
   logic [15:0] addrCnt_q;
   logic [15:0] strCnt_q;
   logic        addrRun_q;
   logic        strRun_q;
   logic [15:0] detachCnt_q;
   logic        tick;
   logic        failLow;
   logic        enable;
   logic        addrExpire;
   logic        strExpire;
   logic        access;
   logic [4:0]  pinSel;
   logic [15:0] regIdx;

   function automatic logic idxHit(input logic [15:0] idx,
                                   input logic [15:0] want);
      idxHit = (idx == want);
   endfunction

   bbseq_tick_div #(
      .TickCycles (TickCycles)
   ) uTick (
      .mclk (mclk),
      .rst  (rst),
      .tick (tick)
   );

   assign access  = psel && penable;
   assign regIdx  = paddr[17:2];
   assign enable  = ctrl_q[`BBSEQ_CTRL_EN_BIT];
   assign pinSel  = ctrl_q[`BBSEQ_CTRL_SEL_MSB:`BBSEQ_CTRL_SEL_LSB];
   // Out-of-range selections read as high, so they never demand a billboard.
   assign failLow = (32'(pinSel) < 32'(PinCount)) ?
                    !generalPurposePin[pinSel] : 1'b0;

   // Once a timer runs, expiry depends only on the tick count, never on further host activity.
   assign addrExpire = addrRun_q && tick &&
                       (addrCnt_q + 16'h1 >= {addrHi_q, addrLo_q});
   assign strExpire  = strRun_q && tick &&
                       (strCnt_q + 16'h1 >= {strHi_q, strLo_q});

   always_ff @(posedge mclk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= access && !pready;
         pslverr <= access && !pready &&
                    !(idxHit(regIdx, `BBSEQ_IDX_ADDR_LO) ||
                      idxHit(regIdx, `BBSEQ_IDX_ADDR_HI) ||
                      idxHit(regIdx, `BBSEQ_IDX_STR_LO) ||
                      idxHit(regIdx, `BBSEQ_IDX_STR_HI) ||
                      idxHit(regIdx, `BBSEQ_IDX_CTRL) ||
                      idxHit(regIdx, `BBSEQ_IDX_STATUS));
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         addrLo_q <= `BBSEQ_RST_LO;
         addrHi_q <= `BBSEQ_RST_HI;
         strLo_q  <= `BBSEQ_RST_LO;
         strHi_q  <= `BBSEQ_RST_HI;
         ctrl_q   <= `BBSEQ_RST_CTRL;
      end else if (access && !pready && pwrite) begin
         if (idxHit(regIdx, `BBSEQ_IDX_ADDR_LO)) begin
            addrLo_q <= pwdata[7:0];
         end
         if (idxHit(regIdx, `BBSEQ_IDX_ADDR_HI)) begin
            addrHi_q <= pwdata[7:0];
         end
         if (idxHit(regIdx, `BBSEQ_IDX_STR_LO)) begin
            strLo_q <= pwdata[7:0];
         end
         if (idxHit(regIdx, `BBSEQ_IDX_STR_HI)) begin
            strHi_q <= pwdata[7:0];
         end
         if (idxHit(regIdx, `BBSEQ_IDX_CTRL)) begin
            ctrl_q <= {2'b00, pwdata[5:0]};
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         prdata <= 32'h0;
      end else if (access && !pready && !pwrite) begin
         if (idxHit(regIdx, `BBSEQ_IDX_ADDR_LO)) begin
            prdata <= {24'h0, addrLo_q};
         end else if (idxHit(regIdx, `BBSEQ_IDX_ADDR_HI)) begin
            prdata <= {24'h0, addrHi_q};
         end else if (idxHit(regIdx, `BBSEQ_IDX_STR_LO)) begin
            prdata <= {24'h0, strLo_q};
         end else if (idxHit(regIdx, `BBSEQ_IDX_STR_HI)) begin
            prdata <= {24'h0, strHi_q};
         end else if (idxHit(regIdx, `BBSEQ_IDX_CTRL)) begin
            prdata <= {24'h0, ctrl_q};
         end else if (idxHit(regIdx, `BBSEQ_IDX_STATUS)) begin
            prdata <= {24'h0, failLow, strRun_q, addrRun_q,
                       deviceConnect, billboardIdentity, state_q};
         end else begin
            prdata <= 32'h0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q     <= SNormal;
         detachCnt_q <= 16'h0;
      end else begin
         unique case (state_q)
            SNormal: begin
               detachCnt_q <= 16'h0;
               if (enable && failLow) begin
                  state_q <= SDetachIn;
               end
            end
            SDetachIn: begin
               detachCnt_q <= detachCnt_q + 16'h1;
               if (detachCnt_q == 16'(DetachCycles - 1)) begin
                  state_q <= SBillboard;
               end
            end
            SBillboard: begin
               detachCnt_q <= 16'h0;
               if (!enable || addrExpire || strExpire) begin
                  state_q <= SDetachOut;
               end
            end
            SDetachOut: begin
               detachCnt_q <= detachCnt_q + 16'h1;
               if (detachCnt_q == 16'(DetachCycles - 1)) begin
                  state_q <= SHold;
               end
            end
            SHold: begin
               // A failure level that stays low must not loop the sequence.
               detachCnt_q <= 16'h0;
               if (!failLow || !enable) begin
                  state_q <= SNormal;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || state_q != SBillboard) begin
         addrRun_q <= 1'b0;
         addrCnt_q <= 16'h0;
      end else begin
         if (hostAddressSet && !addrRun_q) begin
            addrRun_q <= 1'b1;
         end
         if (addrRun_q && tick) begin
            addrCnt_q <= addrCnt_q + 16'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || state_q != SBillboard) begin
         strRun_q <= 1'b0;
         strCnt_q <= 16'h0;
      end else begin
         if (hostStringRequest && !strRun_q) begin
            strRun_q <= 1'b1;
         end
         if (strRun_q && tick) begin
            strCnt_q <= strCnt_q + 16'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         deviceConnect     <= 1'b0;
         billboardIdentity <= 1'b0;
         stringReturn      <= 1'b0;
         bcdVersion        <= 16'h0;
         configuredState   <= `BBSEQ_CFG_UNSPEC;
      end else begin
         deviceConnect <= (state_q != SDetachIn) &&
                          (state_q != SDetachOut);
         billboardIdentity <= (state_q == SBillboard);
         stringReturn <= (state_q == SBillboard) && hostStringRequest;
         bcdVersion <= `BBSEQ_BCD_VERSION;
         configuredState <= `BBSEQ_CFG_UNSPEC;
      end
   end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [17:0] paddr = 18'h00000;
   logic [31:0] pwdata = 32'h00000000;
   logic        failLow = 1'b0;
   logic        addrReq = 1'b0;
   logic        strReq = 1'b0;
   logic [31:0] noise = 32'hffffffff;
   logic [31:0] seed = 32'h00004301;
   logic [31:0] prdata, pins;
   logic        pready, pslverr, deviceConnect, billboardIdentity;
   logic        hAddr, hStr;
   logic [32:0] expQ[$];
   int          bad_count = 0;
   int          n_checks = 0;
   billboard_attach_sequencer #(.TickCycles(10), .DetachCycles(16)) dut (
      .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .generalPurposePin(pins), .hostAddressSet(hAddr),
      .hostStringRequest(hStr), .deviceConnect, .billboardIdentity,
      .stringReturn(), .bcdVersion(), .configuredState());
   bbseq_far_end far (.mclk, .failLow, .noise, .addrReq, .strReq, .pins,
      .hostAddressSet(hAddr), .hostStringRequest(hStr));
   initial forever #5 mclk = ~mclk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input string nm, input logic [32:0] seen, e);
      n_checks++;
      if (seen !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [15:0] idx, input int d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] idx, input logic [32:0] e);
      expQ.push_back(e);
      apb(1'b0, idx, 0);
   endtask
   always @(posedge mclk)
      if (pready === 1'b1 && pwrite === 1'b0 && expQ.size() > 0)
         chk("read", {pslverr, prdata}, expQ.pop_front());
   task automatic waitc(input logic v);
      for (int i = 0; i < 400 && deviceConnect !== v; i++) @(posedge mclk);
      chk("connect", {32'h0, deviceConnect}, {32'h0, v});
   endtask
   task automatic dwell(input logic useStr, input logic [15:0] lo);
      int n;
      seed = xs(seed);
      n = 2 + seed[1:0];
      noise <= seed;
      apb(1'b1, lo, n);
      apb(1'b1, lo + 16'h1, 0);
      rd(lo, 33'(n));
      failLow <= 1'b1;
      waitc(1'b0);
      waitc(1'b1);
      chk("ident", {32'h0, billboardIdentity}, 33'h1);
      addrReq <= !useStr;
      strReq <= useStr;
      @(posedge mclk);
      addrReq <= 1'b0;
      strReq <= 1'b0;
      repeat (n * 10 - 12) @(posedge mclk);
      chk("early", {32'h0, deviceConnect & billboardIdentity}, 33'h1);
      waitc(1'b0);
      waitc(1'b1);
      chk("normal", {32'h0, billboardIdentity}, 33'h0);
      failLow <= 1'b0;
      repeat (30) @(posedge mclk);
      $display("dwell test done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      tally_and_finish;
   end
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++)
         rd(16'h413c + i[15:0], {25'h0, i[0] ? 8'h07 : 8'hd0});
      rd(16'h4140, 33'h14);
      rd(16'h4142, {1'b1, 32'h0});
      apb(1'b1, 16'h4140, 32'hd4);
      rd(16'h4140, 33'h14);
      $display("register test done");
      failLow <= 1'b1;
      repeat (40) @(posedge mclk);
      chk("off", {31'h0, deviceConnect, billboardIdentity}, 33'h2);
      failLow <= 1'b0;
      $display("disable test done");
      apb(1'b1, 16'h4140, 32'h15);
      dwell(1'b0, 16'h413c);
      dwell(1'b1, 16'h413e);
      failLow <= 1'b1;
      waitc(1'b0);
      waitc(1'b1);
      apb(1'b1, 16'h4140, 32'h14);
      waitc(1'b0);
      waitc(1'b1);
      chk("dis", {32'h0, billboardIdentity}, 33'h0);
      rd(16'h4141, 33'h90);
      failLow <= 1'b0;
      repeat (4) @(posedge mclk);
      $display("disable in billboard test done");
      tally_and_finish;
   end
endmodule
